// >>> logic/cfifo_pkg.sv
// package for the cascadable fall-through fifo stage
// assumes one core clock; neighbouring stages share it as the transfer clock
//
// Function
// - depth 65536/131072, one more in fall-through; model holds 16 plus one in both modes
// - asynchronous reading only in standard mode; model has clocked reads only, in both modes
// - flag edges may differ one cycle between devices
// - stages chain output-to-input without glue
// - chain depth is sum of stage depths
// - first word ripples down without read
// - word present drives output-ready low
// - vacancy bubbles up, input-ready goes low
// - chain latency is sum of stage delays
// - ripple delay only for first word
// - output-ready low three cycles after write
// - input-ready low one cycle after free
package cfifo_pkg;
  // ==========================================================
  // sizes
  localparam int unsigned DATA_W = 36;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned PTR_W = 4;
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  // full-size device depths, model keeps FIFO_DEPTH words plus one in the output register
  localparam int unsigned DEPTH_STD_SMALL = 65536;
  localparam int unsigned DEPTH_STD_LARGE = 131072;
  localparam int unsigned DEPTH_FT_EXTRA = 1;
  // ==========================================================
  // reset values
  localparam logic FLAG_N_RST = 1'b1;
  // ==========================================================
  // output register state
  typedef enum logic [0:0] {
    OUT_EMPTY = 1'b0,
    OUT_HELD = 1'b1
  } out_state_t;
  typedef struct packed {
    logic empty_flag_n;
    logic full_flag_n;
    logic output_ready_n;
    logic input_ready_n;
  } flags_t;
endpackage : cfifo_pkg

// >>> logic/cfifo_stage.sv
// one cascadable fifo stage: 16-word buffer plus fall-through output register
// assumes i_core_clk is the shared transfer clock and inputs are same-domain
`timescale 1ns/1ps
`default_nettype none
module cfifo_buf #(
  parameter int unsigned W = 36,
  parameter int unsigned D = 16,
  parameter int unsigned AW = 4
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data,
  output logic [AW:0] o_count
);
  logic [W-1:0] mem_reg [D];
  logic [AW-1:0] wr_reg, rd_reg;
  logic [AW:0] cnt_reg;
  logic push, pop;
  // full at exactly D words; count is one bit wider than the pointers
  assign o_ready = (cnt_reg != (AW+1)'(D));
  assign o_valid = (cnt_reg != '0);
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_data = mem_reg[rd_reg];
  assign o_count = cnt_reg;
  // storage, no reset needed on data
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= i_data;
    end
  end
  // pointers and occupancy
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + AW'(1);
      end
      if (pop) begin
        rd_reg <= rd_reg + AW'(1);
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : cfifo_buf

module cfifo_stage (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // mode strap, caught after reset release
  input wire logic i_fall_through_mode,
  // write side, active low enable
  input wire logic i_wen_n,
  input wire logic [35:0] i_data,
  // read side, active low enable
  input wire logic i_ren_n,
  output logic [35:0] o_data,
  // status flags
  output logic o_empty_flag_n,
  output logic o_full_flag_n,
  output logic o_output_ready_n,
  output logic o_input_ready_n
);
  logic mode_reg, caught_reg;
  logic buf_ready, buf_valid, buf_pop;
  logic [35:0] buf_data;
  logic [cfifo_pkg::CNT_W-1:0] buf_cnt;
  cfifo_pkg::out_state_t out_reg;
  logic [35:0] data_reg;
  logic take, rd;
  logic push_w, next_held, next_ready, mode_now, valid_d_reg;
  logic [cfifo_pkg::CNT_W-1:0] next_cnt;
  cfifo_pkg::flags_t fl;

  // ==========================================================
  // mode strap: sampled on first clock after reset release
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_reg <= 1'b0;
      caught_reg <= 1'b0;
    end else if (!caught_reg) begin
      mode_reg <= i_fall_through_mode;
      caught_reg <= 1'b1;
    end
  end

  // ==========================================================
  // buffer; output register adds the extra fall-through word
  cfifo_buf #(.W(36), .D(cfifo_pkg::FIFO_DEPTH), .AW(cfifo_pkg::PTR_W)) u_buf (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_valid(!i_wen_n),
    .o_ready(buf_ready),
    .i_data(i_data),
    .o_valid(buf_valid),
    .i_ready(buf_pop),
    .o_data(buf_data),
    .o_count(buf_cnt)
  );

  // a read is taken only when the output register holds a word
  assign rd = !i_ren_n && (out_reg == cfifo_pkg::OUT_HELD);
  // fall-through and standard both refill without a read request
  // a word must sit one cycle in the buffer before it may fall through;
  // only a word landing in an empty buffer sees that wait
  assign take = buf_valid && valid_d_reg && ((out_reg == cfifo_pkg::OUT_EMPTY) || rd);
  assign buf_pop = take;

  // settled view of the buffer's valid, gives the fixed first-word latency
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      valid_d_reg <= 1'b0;
    end else begin
      valid_d_reg <= buf_valid;
    end
  end

  // ==========================================================
  // next state of output word and buffer fill, so the flags change on the
  // same edge as the state they describe; a lagging flag would let a
  // neighbouring stage copy a stale word or lose one into a full buffer
  assign push_w = !i_wen_n && buf_ready;
  assign next_held = take || ((out_reg == cfifo_pkg::OUT_HELD) && !rd);
  assign next_cnt = buf_cnt + cfifo_pkg::CNT_W'(push_w) - cfifo_pkg::CNT_W'(take);
  assign next_ready = (next_cnt != cfifo_pkg::CNT_FULL);
  // strap value as it will be once caught
  assign mode_now = caught_reg ? mode_reg : i_fall_through_mode;

  // output register holds one word, giving depth plus one
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      out_reg <= cfifo_pkg::OUT_EMPTY;
      data_reg <= '0;
    end else begin
      if (take) begin
        out_reg <= cfifo_pkg::OUT_HELD;
        data_reg <= buf_data;
      end else if (rd) begin
        out_reg <= cfifo_pkg::OUT_EMPTY;
      end
    end
  end

  // ==========================================================
  // flag registers: write -> buffer -> settle -> out reg and flag together
  // ready flags stay inactive in standard mode; no unclocked read exists
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fl <= '{cfifo_pkg::FLAG_N_RST, cfifo_pkg::FLAG_N_RST,
              cfifo_pkg::FLAG_N_RST, cfifo_pkg::FLAG_N_RST};
    end else begin
      fl.output_ready_n <= !(mode_now && next_held);
      fl.empty_flag_n <= next_held;
      fl.input_ready_n <= !(mode_now && next_ready);
      fl.full_flag_n <= next_ready;
    end
  end

  // outputs straight from flip-flops; standard mode uses empty/full only
  assign o_data = data_reg;
  assign o_output_ready_n = fl.output_ready_n;
  assign o_input_ready_n = fl.input_ready_n;
  assign o_empty_flag_n = fl.empty_flag_n;
  assign o_full_flag_n = fl.full_flag_n;

  // ==========================================================
  // checks
  property p_or_after_write;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (mode_reg && out_reg == cfifo_pkg::OUT_EMPTY && !buf_valid && !i_wen_n && buf_ready)
      |-> ##3 !fl.output_ready_n;
  endproperty
  a_or_after_write: assert property (p_or_after_write) else $error("or late");
  property p_ir_after_read;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (mode_reg && !buf_ready && take && i_wen_n) |-> ##1 !fl.input_ready_n;
  endproperty
  a_ir_after_read: assert property (p_ir_after_read) else $error("ir late");
  property p_no_overflow;
    @(posedge i_core_clk) disable iff (!i_resetn) buf_cnt <= cfifo_pkg::CNT_FULL;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("overflow");
  property p_ready_tracks;
    @(posedge i_core_clk) disable iff (!i_resetn)
      mode_reg |-> (fl.output_ready_n == (out_reg == cfifo_pkg::OUT_EMPTY));
  endproperty
  a_ready_tracks: assert property (p_ready_tracks) else $error("or wrong");
  // input-ready must mirror buffer space exactly, or a neighbour loses words
  property p_space_tracks;
    @(posedge i_core_clk) disable iff (!i_resetn)
      mode_reg |-> (fl.input_ready_n == !buf_ready);
  endproperty
  a_space_tracks: assert property (p_space_tracks) else $error("ir wrong");
  // standard mode never shows the ready flags
  property p_std_quiet;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (caught_reg && !mode_reg) |-> (fl.output_ready_n && fl.input_ready_n);
  endproperty
  a_std_quiet: assert property (p_std_quiet) else $error("ready in standard");
  // a word only falls through after it has settled in the buffer
  property p_take_settled;
    @(posedge i_core_clk) disable iff (!i_resetn)
      take |-> valid_d_reg;
  endproperty
  a_take_settled: assert property (p_take_settled) else $error("early take");
  c_fill: cover property (@(posedge i_core_clk) disable iff (!i_resetn) !buf_ready);
  c_ripple: cover property (@(posedge i_core_clk) disable iff (!i_resetn) take ##1 rd);
  c_both: cover property (@(posedge i_core_clk) disable iff (!i_resetn) !i_wen_n && rd);
  c_bubble: cover property (@(posedge i_core_clk) disable iff (!i_resetn)
    !buf_ready ##1 !fl.input_ready_n);
endmodule : cfifo_stage
`default_nettype wire

// >>> tb/cfifo_sink.sv
// far-end reader model for a chain of fifo stages
// assumes the last stage runs on the same i_core_clk
`timescale 1ns/1ps
`default_nettype none
module cfifo_sink (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // bench control: high holds reads off
  input wire logic i_stall,
  // last stage read side
  input wire logic i_output_ready_n,
  input wire logic [35:0] i_data,
  output logic o_ren_n = 1'b1
);
  logic [35:0] got[$];
  // enable moves off the sampling edge so no race with the stage
  always @(negedge i_core_clk) o_ren_n <= i_stall;
  // a word leaves when enable and output-ready meet at an edge
  always @(posedge i_core_clk) begin
    if (i_resetn && !o_ren_n && !i_output_ready_n) got.push_back(i_data);
  end
endmodule : cfifo_sink
`default_nettype wire

// >>> tb/cfifo_stage_tb_top.sv
// two fall-through stages in series with a sink model behind them
// assumes fall-through strap held high for both stages
`timescale 1ns/1ps
`default_nettype none
module cfifo_stage_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wen_n = 1'b1;
  logic stall = 1'b1;
  logic [35:0] wdata = 36'h0;
  logic [35:0] ab_data, q_data;
  logic a_or_n, a_ir_n, b_or_n, b_ir_n, b_ren_n;
  logic s_wen_n = 1'b1;
  logic s_ren_n = 1'b1;
  logic [71:0] s_q;
  logic [1:0] s_ef_n, s_ff_n, s_or_n, s_ir_n;
  logic s_ef_all_n, s_ff_all_n;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  always #2.5 clk = ~clk;
  // ==========================================================
  // chain: no glue between stages, ready flags drive enables
  cfifo_stage cfifo_stage_i (.i_core_clk(clk), .i_resetn(rstn), .i_fall_through_mode(1'b1),
    .i_wen_n(wen_n), .i_data(wdata), .i_ren_n(b_ir_n), .o_data(ab_data), .o_empty_flag_n(),
    .o_full_flag_n(), .o_output_ready_n(a_or_n), .o_input_ready_n(a_ir_n));
  cfifo_stage cfifo_stage_down_i (.i_core_clk(clk), .i_resetn(rstn), .i_fall_through_mode(1'b1),
    .i_wen_n(a_or_n), .i_data(ab_data), .i_ren_n(b_ren_n), .o_data(q_data), .o_empty_flag_n(),
    .o_full_flag_n(), .o_output_ready_n(b_or_n), .o_input_ready_n(b_ir_n));
  cfifo_sink cfifo_sink_i (.i_core_clk(clk), .i_resetn(rstn), .i_stall(stall),
    .i_output_ready_n(b_or_n), .i_data(q_data), .o_ren_n(b_ren_n));
  // width pair in standard mode: common controls, 72-bit bus, gated flags
  cfifo_stage cfifo_stage_std_lo_i (.i_core_clk(clk), .i_resetn(rstn),
    .i_fall_through_mode(1'b0), .i_wen_n(s_wen_n), .i_data(wdata), .i_ren_n(s_ren_n),
    .o_data(s_q[35:0]), .o_empty_flag_n(s_ef_n[0]), .o_full_flag_n(s_ff_n[0]),
    .o_output_ready_n(s_or_n[0]), .o_input_ready_n(s_ir_n[0]));
  cfifo_stage cfifo_stage_std_hi_i (.i_core_clk(clk), .i_resetn(rstn),
    .i_fall_through_mode(1'b0), .i_wen_n(s_wen_n), .i_data(~wdata), .i_ren_n(s_ren_n),
    .o_data(s_q[71:36]), .o_empty_flag_n(s_ef_n[1]), .o_full_flag_n(s_ff_n[1]),
    .o_output_ready_n(s_or_n[1]), .o_input_ready_n(s_ir_n[1]));
  assign s_ef_all_n = &s_ef_n;
  assign s_ff_all_n = &s_ff_n;
  // ==========================================================
  // reporting
  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // a hang is cut at a ceiling well past the scenarios' length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      report_and_stop();
    end
  end
  // ==========================================================
  // scenarios
  task automatic t_ripple;
    @(negedge clk) wen_n = 1'b0;
    wdata = 36'h9ABCD1234;
    @(negedge clk) wen_n = 1'b1;
    n = 1;
    while (b_or_n !== 1'b0 && n < 20) @(negedge clk) n++;
    check(36'(n >= 6 && n <= 8), 36'h1);
    stall = 1'b0;
    repeat (4) @(negedge clk);
    check(36'(cfifo_sink_i.got.size()), 36'h1);
    check(cfifo_sink_i.got[0], 36'h9ABCD1234);
    check(36'(b_or_n), 36'h1);
  endtask : t_ripple
  task automatic t_fill_drain;
    int k;
    int idle;
    k = 0;
    idle = 0;
    stall = 1'b1;
    cfifo_sink_i.got.delete();
    // write only while the first stage reports space; stop once it stays busy
    while (idle < 12) begin
      @(negedge clk);
      wen_n = a_ir_n;
      wdata = 36'(k);
      if (a_ir_n === 1'b0) k++;
      else idle++;
    end
    wen_n = 1'b1;
    check(36'(k), 36'(2 * (cfifo_pkg::FIFO_DEPTH + 1)));
    check(36'(a_ir_n | b_ir_n), 36'h1);
    stall = 1'b0;
    n = 0;
    while (a_ir_n !== 1'b0 && n < 20) @(negedge clk) n++;
    check(36'(n <= 8), 36'h1);
    repeat (40) @(negedge clk);
    check(36'(cfifo_sink_i.got.size()), 36'(k));
    for (int i = 0; i < cfifo_sink_i.got.size(); i++) check(cfifo_sink_i.got[i], 36'(i));
  endtask : t_fill_drain
  // standard-mode width pair: fill past full, then read back the 17 words held
  task automatic t_standard;
    int i;
    for (i = 0; i < 18; i++) begin
      @(negedge clk);
      s_wen_n = 1'b0;
      wdata = 36'h100 + 36'(i);
    end
    @(negedge clk);
    s_wen_n = 1'b1;
    check(36'(s_ff_all_n), 36'h0);
    check(36'({s_or_n, s_ir_n}), 36'hF);
    for (i = 0; i < 17; i++) begin
      check(36'(s_ef_all_n), 36'h1);
      check(s_q[35:0], 36'h100 + 36'(i));
      check(s_q[71:36], ~(36'h100 + 36'(i)));
      s_ren_n = 1'b0;
      @(negedge clk);
      s_ren_n = 1'b1;
      @(negedge clk);
    end
    check(36'(s_ef_all_n), 36'h0);
    check(36'(s_ff_n), 36'h3);
  endtask : t_standard
  // main sequence: reset, then each scenario once
  initial begin
    repeat (6) @(negedge clk);
    check(36'({a_or_n, a_ir_n, b_or_n, b_ir_n}), 36'hF);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    check(36'(a_ir_n), 36'h0);
    t_ripple();
    t_fill_drain();
    t_standard();
    report_and_stop();
  end
endmodule : cfifo_stage_tb_top
`default_nettype wire
